// ---- rtl/rsec_top.sv ----
/*
  reset and standby entry control of a single-chip microcomputer: takes the
  reset and standby pins, keeps the port direction register, floats the port
  and releases the internal reset in step with a derived bus phase clock.
  assumes pins are synchronous to mclk and board logic drives both pins.
*/
// How it works
// - reset low clears direction register, any phase
// - port pins float while reset held low
// - release and internal reset follow bus phase
// - standby level captured ignoring bus phase
// - standby low puts device in standby
`timescale 1ns/10ps
`include "rsec_map.svh"

module rsec_top (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic                    reset_in_n,
  input  wire logic                    standby_in_n,
  input  wire logic                    cfg_wr_en,
  input  wire rsec_pkg::rsec_port_s    cfg_wdata,
  input  wire logic [`RSEC_PORT_W-1:0] port_in,
  output logic      [`RSEC_PORT_W-1:0] port_out,
  output logic      [`RSEC_PORT_W-1:0] port_oe,
  output logic      [`RSEC_PORT_W-1:0] port_rd,
  output logic                         e_clk,
  output logic                         cpu_rst_n,
  output logic                         standby_act,
  output rsec_pkg::rsec_state_e        seq_state
);
  import rsec_pkg::*;

  localparam logic [`RSEC_CNT_W-1:0] E_LAST   = `RSEC_CNT_W'(`RSEC_E_HALF_CYC - 1);
  localparam logic [`RSEC_SEQ_W-1:0] SEQ_LAST = `RSEC_SEQ_W'(`RSEC_SEQ_E_CYC - 1);

  logic [`RSEC_CNT_W-1:0] e_cnt_ff;
  logic [`RSEC_CNT_W-1:0] nxt_e_cnt;
  logic                   e_ff;
  logic                   e_half_end;
  logic                   e_fall;
  logic                   rsync1_ff;
  logic                   rsync2_ff;
  logic                   standby_in_n_ff;
  logic                   pin_reset;
  rsec_state_e            state_ff;
  rsec_state_e            nxt_state;
  logic [`RSEC_SEQ_W-1:0] seq_cnt_ff;
  logic [`RSEC_SEQ_W-1:0] nxt_seq_cnt;
  logic                   seq_done;
  rsec_port_s             port_ff;
  rsec_port_s             nxt_port;
  logic [`RSEC_PORT_W-1:0] oe_ff;
  logic [`RSEC_PORT_W-1:0] nxt_oe;
  logic [`RSEC_PORT_W-1:0] rd_ff;
  logic                   cpu_rst_n_ff;
  logic                   standby_in_n_act_ff;
  logic                   run_next;
  logic                   live_next;

  // bus phase clock divider decode
  assign e_half_end = (e_cnt_ff == E_LAST);
  assign e_fall     = e_half_end & e_ff;
  assign nxt_e_cnt  = e_half_end ? '0 : e_cnt_ff + `RSEC_CNT_W'(1);

  // bus phase clock divider
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      e_cnt_ff <= '0;
      e_ff     <= 1'b0;
    end else begin
      e_cnt_ff <= nxt_e_cnt;
      e_ff     <= e_ff ^ e_half_end;
    end
  end

  // reset release synchroniser, standby level capture
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rsync1_ff <= 1'b0;
      rsync2_ff <= 1'b0;
      standby_in_n_ff   <= 1'b1;
    end else begin
      rsync1_ff <= reset_in_n;
      rsync2_ff <= rsync1_ff & reset_in_n; // short pulse clears both stages
      standby_in_n_ff   <= standby_in_n;
    end
  end

  // pin reset acts at once; sequence decode
  assign pin_reset = ~reset_in_n;
  assign seq_done  = e_fall & (seq_cnt_ff == SEQ_LAST);

  // sequencer next state
  always_comb begin
    nxt_state   = state_ff;
    nxt_seq_cnt = seq_cnt_ff;
    case (state_ff)
      ST_HOLD: begin
        nxt_seq_cnt = '0;
        if (rsync2_ff) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (e_fall) begin
          nxt_state = ST_SEQ;
        end
      end
      ST_SEQ: begin
        if (seq_done) begin
          nxt_state = ST_RUN;
        end else if (e_fall) begin
          nxt_seq_cnt = seq_cnt_ff + `RSEC_SEQ_W'(1);
        end
      end
      ST_RUN: begin
        nxt_seq_cnt = '0;
        if (!standby_in_n_ff) begin
          nxt_state = ST_STANDBY_IN_N;
        end
      end
      ST_STANDBY_IN_N: begin
        if (standby_in_n_ff) begin
          nxt_state = ST_SEQ;
        end
      end
      default: begin
        nxt_state   = ST_HOLD;
        nxt_seq_cnt = '0;
      end
    endcase
    if (pin_reset) begin
      nxt_state   = ST_HOLD;
      nxt_seq_cnt = '0;
    end
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_ff   <= ST_HOLD;
      seq_cnt_ff <= '0;
    end else begin
      state_ff   <= nxt_state;
      seq_cnt_ff <= nxt_seq_cnt;
    end
  end

  // port register next values and output enables
  assign run_next  = (nxt_state == ST_RUN);
  assign live_next = run_next | (nxt_state == ST_STANDBY_IN_N);
  assign nxt_oe    = run_next ? nxt_port.dir : '0;

  always_comb begin
    nxt_port = port_ff;
    if (pin_reset) begin
      nxt_port.dir = `RSEC_DIR_RST;
    end else if (cfg_wr_en && state_ff == ST_RUN) begin
      nxt_port = cfg_wdata;
    end
  end

  // port and status registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      port_ff.dir  <= `RSEC_DIR_RST;
      port_ff.data <= `RSEC_DATA_RST;
      oe_ff        <= '0;
      rd_ff        <= '0;
      cpu_rst_n_ff <= 1'b0;
      standby_in_n_act_ff  <= 1'b0;
    end else begin
      port_ff      <= nxt_port;
      oe_ff        <= nxt_oe;
      rd_ff        <= port_in;
      cpu_rst_n_ff <= live_next;
      standby_in_n_act_ff  <= (nxt_state == ST_STANDBY_IN_N);
    end
  end

  // outputs straight from flip-flops
  assign port_out    = port_ff.data;
  assign port_oe     = oe_ff;
  assign port_rd     = rd_ff;
  assign e_clk       = e_ff;
  assign cpu_rst_n   = cpu_rst_n_ff;
  assign standby_act = standby_in_n_act_ff;
  assign seq_state   = state_ff;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_pin_released;
    !reset_in_n ##1 reset_in_n;
  endsequence

  sequence s_hold_two;
    (state_ff == ST_HOLD) ##1 (state_ff == ST_HOLD);
  endsequence

  chk_ddr_clear: assert property (
    !reset_in_n |=> (port_ff.dir == `RSEC_DIR_RST) && (state_ff == ST_HOLD))
    else $error("direction register not cleared on reset pin");

  chk_pins_float: assert property (
    !reset_in_n [*2] |=> (port_oe == '0) && !cpu_rst_n)
    else $error("port driven while reset pin low");

  chk_release_phase: assert property (
    $rose(cpu_rst_n) |-> $past(e_fall) && (state_ff == ST_RUN))
    else $error("internal reset released off the bus phase");

  chk_seq_entry: assert property (
    (state_ff == ST_WAIT) && reset_in_n && !e_fall |=> (state_ff == ST_WAIT))
    else $error("release left wait without bus phase edge");

  chk_standby_in_n_capture: assert property (
    $past(rst_b) |-> (standby_in_n_ff == $past(standby_in_n)))
    else $error("standby level not captured on every clock");

  chk_standby_in_n_enter: assert property (
    (state_ff == ST_RUN) && !standby_in_n_ff && reset_in_n |=> standby_act && (port_oe == '0))
    else $error("standby not entered on low standby level");

  chk_sync_depth: assert property (
    s_pin_released |-> s_hold_two)
    else $error("reset released before two synchroniser stages");

endmodule

// ---- rtl/rsec_map.svh ----
/*
  named offsets, reset values and timing counts of the reset and standby
  sequencer. assumes a 200 MHz mclk and a 1 MHz bus phase clock.
*/
`ifndef RSEC_MAP_SVH
`define RSEC_MAP_SVH

// clock periods in ns
`define RSEC_CLK_PERIOD_NS 5
`define RSEC_E_PERIOD_NS   1000
// mclk cycles per half period of the bus phase clock (longest time, rounds down)
`define RSEC_E_HALF_CYC    (`RSEC_E_PERIOD_NS / `RSEC_CLK_PERIOD_NS / 2)
`define RSEC_CNT_W         8
// bus phase cycles of internal reset after release
`define RSEC_SEQ_E_CYC     3
`define RSEC_SEQ_W         2
// port geometry and reset values
`define RSEC_PORT_W        8
`define RSEC_DIR_RST       8'h00
`define RSEC_DATA_RST      8'h00

`endif

// ---- rtl/rsec_pkg.sv ----
/*
  types shared by the reset and standby sequencer: state codes and the
  port configuration carrier. assumes rsec_map.svh sits on the include path.
*/
`include "rsec_map.svh"

package rsec_pkg;

  // one-hot sequencer states
  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_WAIT = 5'h02,
    ST_SEQ  = 5'h04,
    ST_RUN  = 5'h08,
    ST_STANDBY_IN_N = 5'h10
  } rsec_state_e;

  // direction and data of the parallel port
  typedef struct packed {
    logic [`RSEC_PORT_W-1:0] dir;
    logic [`RSEC_PORT_W-1:0] data;
  } rsec_port_s;

endpackage

// ---- tb/rsec_board.sv ----
/*
  board model driving the reset and standby pins of the sequencer.
  assumes requests change at the mclk rising edge.
*/
`timescale 1ns/10ps

module rsec_board (
  input  wire logic mclk,
  input  wire logic hold_rst,
  input  wire logic ask_standby_in_n,
  output logic      reset_in_n   = 1'h0,
  output logic      standby_in_n = 1'h1
);
  // pins follow the requests one edge later
  always @(posedge mclk) begin
    reset_in_n   <= ~hold_rst;
    standby_in_n <= ~ask_standby_in_n;
  end
endmodule

// ---- tb/tb.sv ----
/*
  self-checking bench of the reset and standby sequencer.
  assumes the board model and the design share mclk.
*/
`timescale 1ns/10ps
`include "rsec_map.svh"

module tb;
  import rsec_pkg::*;
  logic                    mclk      = 1'h0;
  logic                    rst_b     = 1'h0;
  logic                    hold_rst  = 1'h1;
  logic                    ask_standby_in_n  = 1'h0;
  logic                    cfg_wr_en = 1'h0;
  rsec_port_s              cfg_wdata = '0;
  rsec_port_s              wr;
  logic [`RSEC_PORT_W-1:0] port_in   = '0;
  logic [`RSEC_PORT_W-1:0] pin;
  logic [`RSEC_PORT_W-1:0] port_out, port_oe, port_rd;
  logic                    e_clk, cpu_rst_n, standby_act, reset_in_n, standby_in_n;
  rsec_state_e             seq_state;
  int                      miscompares = 0;
  int                      check_count = 0;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  rsec_board u_board (.mclk(mclk), .hold_rst(hold_rst), .ask_standby_in_n(ask_standby_in_n),
    .reset_in_n(reset_in_n), .standby_in_n(standby_in_n));

  rsec_top u_dut (.mclk(mclk), .rst_b(rst_b), .reset_in_n(reset_in_n),
    .standby_in_n(standby_in_n), .cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .port_rd(port_rd),
    .e_clk(e_clk), .cpu_rst_n(cpu_rst_n), .standby_act(standby_act),
    .seq_state(seq_state));

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // settle just after an edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // bounded wait for run; internal reset must end in a low bus phase
  task automatic wait_run();
    int n;
    n = 0;
    while (seq_state !== ST_RUN && n < 2000) begin
      step(1);
      n++;
    end
    check(n < 2000, 1'h1);
    if (n >= 2000)
      conclude();
    check({e_clk, cpu_rst_n}, 2'h1);
  endtask

  // main sequence
  initial begin
    void'($urandom(32'hb515_8c71));
    step(2);
    @(posedge mclk) rst_b <= 1'h1;
    step(3);
    check({port_oe, cpu_rst_n, seq_state}, {8'h00, 1'h0, ST_HOLD});
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk) hold_rst <= 1'h0;
      step(3);
      check(seq_state, ST_HOLD);
      step(1);
      check(seq_state, ST_WAIT);
      wait_run();
      check(port_oe, 8'h00);
      wr  = rsec_port_s'(16'($urandom));
      pin = 8'($urandom);
      @(posedge mclk) begin
        cfg_wr_en <= 1'h1;
        cfg_wdata <= wr;
        port_in   <= pin;
      end
      @(posedge mclk) cfg_wr_en <= 1'h0;
      #1;
      check({port_out, port_oe}, {wr.data, wr.dir});
      check(port_rd, pin);
      repeat ($urandom_range(199)) @(posedge mclk);
      if (k % 2 == 0) begin
        @(posedge mclk) ask_standby_in_n <= 1'h1;
        step(2);
        check(standby_act, 1'h0);
        step(1);
        check({standby_act, port_oe, seq_state}, {1'h1, 8'h00, ST_STANDBY_IN_N});
        repeat ($urandom_range(199)) @(posedge mclk);
        @(posedge mclk) ask_standby_in_n <= 1'h0;
        step(3);
        wait_run();
        check(port_oe, wr.dir);
        repeat ($urandom_range(199)) @(posedge mclk);
      end
      @(posedge mclk) hold_rst <= 1'h1;
      step(3);
      check({port_oe, cpu_rst_n, seq_state}, {8'h00, 1'h0, ST_HOLD});
      // write while the reset pin is low must be refused
      pin = 8'($urandom);
      @(posedge mclk) begin
        cfg_wr_en <= 1'h1;
        cfg_wdata <= ~wr;
        port_in   <= pin;
      end
      @(posedge mclk) cfg_wr_en <= 1'h0;
      #1;
      check({port_out, port_oe}, {wr.data, 8'h00});
      check(port_rd, pin);
    end
    conclude();
  end
endmodule
